// >>> rtl/rifpc_top.sv
/*
  reset, external interrupt, interrupt acknowledge and flag pin control.
  assumes one 20 mhz sys_clk, synchronous active-high reset of the logic,
  a single ahb-lite master, and pins that come from outside the clock.
*/
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
// Overview of operation
// - reset pin is asynchronous; late setup may cost one extra cycle
// - reset loads bus control with seven software wait states
// - reset vector fetched twice: seven waits, none in microcomputer mode
// - reset low floats flag, serial and timer pins
// - during reset buses float, strobes and acknowledge driven high
// - read/write output floats during reset
// - bus hold request is accepted while reset is active
// - external interrupt lines are level sensitive
// - interrupt lines sampled on each phase-a falling edge
// - detected interrupts act only at instruction fetch boundaries
// - same line can raise a new interrupt every two phase-a cycles
// - interrupt lines asynchronous; late setup may add a cycle
// - acknowledge low from decode start to read start
// - interlocked store drives flag zero high at execute start
// - stalled store drives its address only when it executes
// - interlocked load drives flag zero low, samples flag one
// - signal interlock drives flag zero low then high, samples flag one
// - output-value bit write changes pin after next phase-b rise; flag zero ignores it after any interlock until reset
// - direction bit selects input or output, drive after phase-b rise; flag zero stays driven after any interlock until reset
// - input flag captured on phase-a fall into input-value bit
`timescale 1ns/1ns
`include "rifpc_defs.svh"

module rifpc_top #(
  parameter int IRQ_LINES = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic hold_req_n,
  input wire logic [IRQ_LINES-1:0] ext_irq_lines,
  input wire logic flag_pin_zero_in,
  input wire logic flag_pin_one_in,
  output rifpc_pkg::rifpc_pin_drv_t flag_pin_zero_drv,
  output rifpc_pkg::rifpc_pin_drv_t flag_pin_one_drv,
  output logic periph_pins_oe_n,
  output rifpc_pkg::rifpc_bus_t bus_ctl,
  output logic irq_ack_strobe,
  output logic hold_ack,
  output logic store_addr_drive,
  output logic clock_phase_a,
  output logic clock_phase_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import rifpc_pkg::*;

  // -------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  // -------------------------------------------------------------
  localparam int NSYNC = IRQ_LINES + 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a, sync_b, sync_c, pin_q;
  logic [NSYNC-1:0] next_pin_q;
  // reset pin starts asserted, so a logic reset cannot let the sequence run early
  localparam logic [NSYNC-1:0] SYNC_IDLE = ~(NSYNC'(1) << IRQ_LINES);
  assign pin_raw = {flag_pin_one_in, flag_pin_zero_in, hold_req_n, reset_pin_n, ext_irq_lines};

  // filtered level only moves when the last two stages agree
  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < NSYNC; i++) begin
      if (sync_b[i] == sync_c[i]) begin
        next_pin_q[i] = sync_c[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
      sync_c <= SYNC_IDLE;
      pin_q <= SYNC_IDLE;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
      pin_q <= next_pin_q;
    end
  end

  logic [IRQ_LINES-1:0] irq_lvl_n;
  logic rst_pin_n, hold_n, flag0_lvl, flag1_lvl;
  assign irq_lvl_n = pin_q[IRQ_LINES-1:0];
  assign rst_pin_n = pin_q[IRQ_LINES];
  assign hold_n = pin_q[IRQ_LINES+1];
  assign flag0_lvl = pin_q[IRQ_LINES+2];
  assign flag1_lvl = pin_q[IRQ_LINES+3];

  // -------------------------------------------------------------
  // two-phase clock: a high on one edge, b high on the next
  // -------------------------------------------------------------
  rifpc_phase_t phase, next_phase;
  logic fall_a, rise_b;

  // phase a falls exactly where phase b rises, so they never overlap
  always_comb begin
    case (phase)
      RIFPC_PH_A: next_phase = RIFPC_PH_B;
      RIFPC_PH_B: next_phase = RIFPC_PH_A;
      default: next_phase = RIFPC_PH_A;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase <= RIFPC_PH_A;
    end else begin
      phase <= next_phase;
    end
  end

  assign clock_phase_a = phase[0];
  assign clock_phase_b = phase[1];
  assign fall_a = (phase == RIFPC_PH_A); // next edge takes a low and b high
  assign rise_b = fall_a;

  // -------------------------------------------------------------
  // reset sequence and vector fetches
  // -------------------------------------------------------------
  rifpc_state_t state, next_state;
  logic [2:0] wait_cfg, next_wait_cfg;
  logic [2:0] wait_cnt, next_wait_cnt;
  logic [1:0] fetch_cnt, next_fetch_cnt;
  logic mc_mode, next_mc_mode;
  logic in_reset;
  logic wr_busctl;
  logic [2:0] wdata_wait;

  assign in_reset = (state == RIFPC_S_RESET);

  // pin reset restarts the sequence; release begins two vector fetches
  always_comb begin
    next_state = state;
    next_wait_cfg = wait_cfg;
    next_wait_cnt = wait_cnt;
    next_fetch_cnt = fetch_cnt;
    if (wr_busctl) begin
      next_wait_cfg = wdata_wait;
    end
    case (state)
      RIFPC_S_RESET: begin
        next_wait_cfg = `RIFPC_WAIT_RESET;
        next_fetch_cnt = `RIFPC_VEC_FETCHES;
        if (rst_pin_n && fall_a) begin
          next_state = RIFPC_S_FETCH;
        end
      end
      RIFPC_S_FETCH: begin
        // microcomputer mode fetches internally with no wait states
        next_wait_cnt = mc_mode ? 3'h0 : wait_cfg;
        next_state = RIFPC_S_WAIT;
      end
      RIFPC_S_WAIT: begin
        if (wait_cnt != 3'h0) begin
          next_wait_cnt = wait_cnt - 3'h1;
        end else if (fetch_cnt == 2'h1) begin
          next_fetch_cnt = 2'h0;
          next_state = RIFPC_S_RUN;
        end else begin
          next_fetch_cnt = fetch_cnt - 2'h1;
          next_state = RIFPC_S_FETCH;
        end
      end
      RIFPC_S_RUN: ;
      default: next_state = RIFPC_S_RESET;
    endcase
    if (!rst_pin_n) begin
      next_state = RIFPC_S_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= RIFPC_S_RESET;
      wait_cfg <= `RIFPC_WAIT_RESET;
      wait_cnt <= 3'h0;
      fetch_cnt <= 2'h0;
      mc_mode <= 1'b0;
    end else begin
      state <= next_state;
      wait_cfg <= next_wait_cfg;
      wait_cnt <= next_wait_cnt;
      fetch_cnt <= next_fetch_cnt;
      mc_mode <= next_mc_mode;
    end
  end

  // hold is honoured in every state, reset included
  assign hold_ack = !hold_n;
  assign periph_pins_oe_n = in_reset;
  assign bus_ctl.bus_release = in_reset || hold_ack;
  assign bus_ctl.bus_strobe_n = 1'b1;
  assign bus_ctl.page_strobe_n = 1'b1;
  assign bus_ctl.rw_oe_n = in_reset;

  // -------------------------------------------------------------
  // external interrupts: level sampled on phase-a falls
  // -------------------------------------------------------------
  logic [IRQ_LINES-1:0] irq_pend, next_irq_pend;
  logic [IRQ_LINES-1:0] irq_block, next_irq_block;
  logic [IRQ_LINES-1:0] irq_taken;
  logic fetch_bound;

  // a line still low two falls later counts as a fresh request
  always_comb begin
    next_irq_pend = irq_pend & ~irq_taken;
    next_irq_block = irq_block;
    if (fall_a) begin
      for (int i = 0; i < IRQ_LINES; i++) begin
        next_irq_block[i] = 1'b0;
        if (!irq_lvl_n[i] && !irq_block[i]) begin
          next_irq_pend[i] = 1'b1;
          next_irq_block[i] = 1'b1;
        end
      end
    end
    if (in_reset) begin
      next_irq_pend = '0;
      next_irq_block = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_pend <= '0;
      irq_block <= '0;
    end else begin
      irq_pend <= next_irq_pend;
      irq_block <= next_irq_block;
    end
  end

  // -------------------------------------------------------------
  // core commands: acknowledge, interlocks, fetch boundary
  // -------------------------------------------------------------
  logic cmd_wr;
  logic [31:0] cmd_data;
  logic ack_busy, next_ack_busy;
  logic ack_q, next_ack_q;
  logic st_pend, next_st_pend;
  logic st_addr, next_st_addr;
  logic ld_pend, next_ld_pend;
  logic sg_pend, next_sg_pend;
  logic sg_step, next_sg_step;
  logic flag1_smp, next_flag1_smp;
  logic f0_force, next_f0_force;
  logic f0_force_val, next_f0_force_val;
  logic store_go;
  logic mc_mode_cmd, next_mc_mode_cmd;

  assign fetch_bound = cmd_wr && cmd_data[`RIFPC_C_FETCH];
  // pending lines are handed over only at a fetch boundary
  assign irq_taken = fetch_bound ? irq_pend : '0;
  assign store_go = cmd_wr && cmd_data[`RIFPC_C_STORE];

  // acknowledge spans one phase cycle from decode to read
  always_comb begin
    next_ack_busy = ack_busy;
    next_ack_q = ack_q;
    next_st_pend = st_pend && !store_go;
    next_st_addr = 1'b0;
    next_ld_pend = ld_pend;
    next_sg_pend = sg_pend;
    next_sg_step = sg_step;
    next_flag1_smp = flag1_smp;
    next_f0_force = f0_force;
    next_f0_force_val = f0_force_val;
    next_mc_mode_cmd = mc_mode_cmd;
    if (cmd_wr) begin
      next_mc_mode_cmd = cmd_data[`RIFPC_C_MCMODE];
      if (cmd_data[`RIFPC_C_ACK]) begin
        next_ack_busy = 1'b1;
      end
      if (cmd_data[`RIFPC_C_LOAD]) begin
        next_ld_pend = 1'b1;
      end
      if (cmd_data[`RIFPC_C_SIGNAL_INTERLOCK_INSTR]) begin
        next_sg_pend = 1'b1;
        next_sg_step = 1'b0;
      end
    end
    if (clock_phase_b && ack_busy && !ack_q) begin
      next_ack_q = 1'b1;
    end else if (clock_phase_b && ack_q) begin
      next_ack_q = 1'b0;
      next_ack_busy = 1'b0;
    end
    if (store_go) begin
      next_f0_force = 1'b1;
      next_f0_force_val = 1'b1;
      next_st_pend = hold_ack;
      next_st_addr = !hold_ack;
    end else if (st_pend && !hold_ack) begin
      next_st_addr = 1'b1;
      next_st_pend = 1'b0;
    end
    if (rise_b && ld_pend) begin
      next_f0_force = 1'b1;
      next_f0_force_val = 1'b0;
      next_ld_pend = 1'b0;
      next_flag1_smp = flag1_lvl;
    end
    if (rise_b && sg_pend) begin
      next_f0_force = 1'b1;
      next_f0_force_val = sg_step;
      next_flag1_smp = flag1_lvl;
      next_sg_pend = !sg_step;
      next_sg_step = 1'b1;
    end
    if (in_reset) begin
      next_f0_force = 1'b0;
      next_ld_pend = 1'b0;
      next_sg_pend = 1'b0;
      next_st_pend = 1'b0;
      next_ack_busy = 1'b0;
      next_ack_q = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_busy <= 1'b0;
      ack_q <= 1'b0;
      st_pend <= 1'b0;
      st_addr <= 1'b0;
      ld_pend <= 1'b0;
      sg_pend <= 1'b0;
      sg_step <= 1'b0;
      flag1_smp <= 1'b1;
      f0_force <= 1'b0;
      f0_force_val <= 1'b0;
      mc_mode_cmd <= 1'b0;
    end else begin
      ack_busy <= next_ack_busy;
      ack_q <= next_ack_q;
      st_pend <= next_st_pend;
      st_addr <= next_st_addr;
      ld_pend <= next_ld_pend;
      sg_pend <= next_sg_pend;
      sg_step <= next_sg_step;
      flag1_smp <= next_flag1_smp;
      f0_force <= next_f0_force;
      f0_force_val <= next_f0_force_val;
      mc_mode_cmd <= next_mc_mode_cmd;
    end
  end

  assign irq_ack_strobe = !ack_q; // active low; high in reset
  assign store_addr_drive = st_addr;

  // -------------------------------------------------------------
  // flag control register and pin drivers
  // -------------------------------------------------------------
  logic [7:0] flag_ctl, next_flag_ctl;
  logic [1:0] drv_en, next_drv_en;
  logic [1:0] drv_val, next_drv_val;
  logic wr_flag;
  logic [7:0] wdata_flag;

  // software bits are staged, pins follow only at a phase-b rise
  always_comb begin
    next_flag_ctl = flag_ctl;
    next_drv_en = drv_en;
    next_drv_val = drv_val;
    if (wr_flag) begin
      next_flag_ctl[`RIFPC_F0_DIR] = wdata_flag[`RIFPC_F0_DIR];
      next_flag_ctl[`RIFPC_F0_OUT] = wdata_flag[`RIFPC_F0_OUT];
      next_flag_ctl[`RIFPC_F1_DIR] = wdata_flag[`RIFPC_F1_DIR];
      next_flag_ctl[`RIFPC_F1_OUT] = wdata_flag[`RIFPC_F1_OUT];
    end
    if (fall_a) begin
      if (!flag_ctl[`RIFPC_F0_DIR]) begin
        next_flag_ctl[`RIFPC_F0_IN] = flag0_lvl;
      end
      if (!flag_ctl[`RIFPC_F1_DIR]) begin
        next_flag_ctl[`RIFPC_F1_IN] = flag1_lvl;
      end
    end
    if (rise_b) begin
      next_drv_en = {flag_ctl[`RIFPC_F1_DIR], flag_ctl[`RIFPC_F0_DIR] || f0_force};
      next_drv_val = {flag_ctl[`RIFPC_F1_OUT], f0_force ? f0_force_val
        : flag_ctl[`RIFPC_F0_OUT]};
    end
    if (in_reset) begin
      next_flag_ctl = 8'h00;
      next_drv_en = 2'b00;
      next_drv_val = 2'b00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_ctl <= 8'h00;
      drv_en <= 2'b00;
      drv_val <= 2'b00;
    end else begin
      flag_ctl <= next_flag_ctl;
      drv_en <= next_drv_en;
      drv_val <= next_drv_val;
    end
  end

  assign flag_pin_zero_drv.out = drv_val[0];
  assign flag_pin_zero_drv.oe_n = !drv_en[0];
  assign flag_pin_one_drv.out = drv_val[1];
  assign flag_pin_one_drv.oe_n = !drv_en[1];

  // -------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // -------------------------------------------------------------
  logic dp_wr, next_dp_wr;
  logic [7:0] dp_ofs, next_dp_ofs;
  logic [31:0] rdata, next_rdata;

  always_comb begin
    next_dp_wr = hsel && hready && htrans[1] && hwrite;
    next_dp_ofs = haddr[7:0];
    next_rdata = rdata;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `RIFPC_OFS_FLAGCTL: next_rdata = {24'h000000, flag_ctl};
        `RIFPC_OFS_CORE: next_rdata = {26'h0000000, mc_mode_cmd, 5'h00};
        `RIFPC_OFS_IRQ: next_rdata = {{(32-IRQ_LINES){1'b0}}, irq_pend};
        `RIFPC_OFS_STATUS: next_rdata = {27'h0000000, flag1_smp, hold_ack,
          st_pend, ack_busy, in_reset};
        `RIFPC_OFS_BUSCTL: next_rdata = {29'h00000000, wait_cfg};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dp_wr <= 1'b0;
      dp_ofs <= 8'h00;
      rdata <= 32'h00000000;
    end else begin
      dp_wr <= next_dp_wr;
      dp_ofs <= next_dp_ofs;
      rdata <= next_rdata;
    end
  end

  assign wr_flag = dp_wr && (dp_ofs == `RIFPC_OFS_FLAGCTL);
  assign cmd_wr = dp_wr && (dp_ofs == `RIFPC_OFS_CORE);
  assign wr_busctl = dp_wr && (dp_ofs == `RIFPC_OFS_BUSCTL);
  assign cmd_data = hwdata;
  assign wdata_flag = hwdata[7:0];
  assign wdata_wait = hwdata[2:0];
  assign next_mc_mode = mc_mode_cmd;
  assign hrdata = rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_reset_waits: assert property (in_reset |=> wait_cfg == `RIFPC_WAIT_RESET)
    else $error("bus wait states not seven after reset");
  a_reset_float: assert property (in_reset |-> periph_pins_oe_n && bus_ctl.rw_oe_n)
    else $error("pins driven during reset");
  a_reset_flags: assert property (in_reset |=> flag_pin_zero_drv.oe_n)
    else $error("flag pin driven during reset");
  a_reset_strobes: assert property (in_reset |-> bus_ctl.bus_release && irq_ack_strobe)
    else $error("bus not released in reset");
  a_hold_accept: assert property (!hold_n |-> hold_ack)
    else $error("hold not accepted");
  a_irq_level: assert property (fall_a && !irq_lvl_n[0] && !irq_block[0] && !in_reset
    |=> irq_pend[0])
    else $error("low level not captured");
  a_irq_boundary: assert property (irq_pend[0] && !fetch_bound && !in_reset
    |=> irq_pend[0])
    else $error("interrupt consumed off fetch boundary");
  a_ack_span: assert property ($fell(irq_ack_strobe) |=> !irq_ack_strobe ##1 irq_ack_strobe)
    else $error("acknowledge width wrong");
  a_store_flag: assert property (store_go && !in_reset ##1 rise_b |=> !flag_pin_zero_drv.oe_n
    && flag_pin_zero_drv.out)
    else $error("store did not raise flag zero");
  a_flag_capture: assert property (fall_a && !flag_ctl[`RIFPC_F0_DIR] && !in_reset
    |=> flag_ctl[`RIFPC_F0_IN] == $past(flag0_lvl))
    else $error("flag input not captured");
  a_phase_excl: assert property (clock_phase_a != clock_phase_b)
    else $error("phases overlap");

  c_fetch_done: cover property (state == RIFPC_S_WAIT ##1 state == RIFPC_S_RUN);
  c_ack_pulse: cover property ($fell(irq_ack_strobe));
  c_signal_interlock_instr_seq: cover property (sg_pend ##[1:6] !sg_pend);
endmodule // rifpc_top

// >>> rtl/rifpc_defs.svh
/*
  constants for the reset, interrupt and flag pin control block:
  register offsets, field positions, reset values and timing counts.
  assumes a 32-bit ahb-lite register bus and a 20 mhz sys_clk.
*/
`ifndef RIFPC_DEFS_SVH
`define RIFPC_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define RIFPC_OFS_FLAGCTL 8'h00
`define RIFPC_OFS_CORE 8'h04
`define RIFPC_OFS_IRQ 8'h08
`define RIFPC_OFS_STATUS 8'h0C
`define RIFPC_OFS_BUSCTL 8'h10

// ---------------------------------------------------------------
// field positions in the flag control register
// ---------------------------------------------------------------
`define RIFPC_F0_DIR 1
`define RIFPC_F0_OUT 2
`define RIFPC_F0_IN 3
`define RIFPC_F1_DIR 5
`define RIFPC_F1_OUT 6
`define RIFPC_F1_IN 7

// ---------------------------------------------------------------
// core command bits (write to core register)
// ---------------------------------------------------------------
`define RIFPC_C_ACK 0
`define RIFPC_C_STORE 1
`define RIFPC_C_LOAD 2
`define RIFPC_C_SIGNAL_INTERLOCK_INSTR 3
`define RIFPC_C_FETCH 4
`define RIFPC_C_MCMODE 5

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define RIFPC_WAIT_RESET 3'h7
`define RIFPC_RESET_HOLD 4'hA
`define RIFPC_VEC_FETCHES 2'h2
`define RIFPC_IRQ_GAP 2'h2

`endif

// >>> rtl/rifpc_pkg.sv
/*
  types shared by the pin control block and its surroundings.
  assumes the constants header is available to the includer.
*/
package rifpc_pkg;
  // phase of the internal two-phase clock
  typedef enum logic [1:0] {
    RIFPC_PH_A = 2'b01,
    RIFPC_PH_B = 2'b10
  } rifpc_phase_t;

  // reset and vector fetch sequence
  typedef enum logic [3:0] {
    RIFPC_S_RESET = 4'b0001,
    RIFPC_S_FETCH = 4'b0010,
    RIFPC_S_WAIT = 4'b0100,
    RIFPC_S_RUN = 4'b1000
  } rifpc_state_t;

  // two-way pin: output level, output enable (low drives)
  typedef struct packed {
    logic out;
    logic oe_n;
  } rifpc_pin_drv_t;

  // outputs seen on the external bus during reset
  typedef struct packed {
    logic bus_release;
    logic bus_strobe_n;
    logic page_strobe_n;
    logic rw_oe_n;
  } rifpc_bus_t;
endpackage

// >>> tb/rifpc_far_side.sv
/*
  far-side model: reset source, interrupt requesters, hold requester
  and flag pin partner. assumes the bench steps its inputs at sys_clk rises.
*/
`timescale 1ns/1ns
module rifpc_far_side (
  input wire logic sys_clk,
  input wire logic rst_req,
  input wire logic [3:0] irq_go,
  input wire logic [3:0] irq_level,
  input wire logic hold_req,
  input wire logic flag_level,
  input rifpc_pkg::rifpc_pin_drv_t flag_pin_zero_drv,
  input rifpc_pkg::rifpc_pin_drv_t flag_pin_one_drv,
  output logic reset_pin_n,
  output logic [3:0] ext_irq_lines,
  output logic hold_req_n,
  output logic flag_pin_zero_in,
  output logic flag_pin_one_in
);
  import rifpc_pkg::*;
  logic [4:0] low_cnt = 5'h00;
  logic [1:0] left [4] = '{default: 2'h0};

  // reset low for twenty sys_clk at least, even if the bench asks less
  always @(posedge sys_clk) begin
    if (rst_req) begin
      reset_pin_n <= 1'b0;
      low_cnt <= 5'h00;
    end else if (!reset_pin_n) begin
      low_cnt <= low_cnt + 5'h01;
      if (low_cnt >= 5'h14) reset_pin_n <= 1'b1;
    end
  end

  // a pulse lasts one phase-a period, so exactly one phase-a fall sees it
  always @(posedge sys_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (irq_go[i]) left[i] <= 2'h2;
      else if (left[i] != 2'h0) left[i] <= left[i] - 2'h1;
    end
  end

  // lines are low active; a held level models a stuck requester
  always_comb begin
    for (int i = 0; i < 4; i++) ext_irq_lines[i] = !(left[i] != 2'h0 || irq_level[i]);
  end

  // the partner drives a flag pin only while the device lets it go
  assign hold_req_n = !hold_req;
  assign flag_pin_zero_in = flag_pin_zero_drv.oe_n ? flag_level : flag_pin_zero_drv.out;
  assign flag_pin_one_in = flag_pin_one_drv.oe_n ? flag_level : flag_pin_one_drv.out;
endmodule // rifpc_far_side

// >>> tb/test_reset_irq_flag_pin_control.sv
/*
  self-checking bench for the pin control block.
  assumes the far-side model and a single ahb-lite master in this module.
*/
`timescale 1ns/1ns
`include "rifpc_defs.svh"
module test_reset_irq_flag_pin_control;
  import rifpc_pkg::*;
  logic sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, d;
  logic reset_pin_n, hold_req_n, hold_ack, store_addr_drive, irq_ack_strobe;
  logic periph_pins_oe_n, clock_phase_a, clock_phase_b, f0_in, f1_in, p;
  logic rst_req, hold_req, flag_level;
  logic [3:0] ext_irq_lines, irq_go, irq_level;
  rifpc_pin_drv_t f0_drv, f1_drv;
  rifpc_bus_t bus_ctl;
  int fails = 0;
  int checked = 0;
  int k, n;

  assign hready = hreadyout;
  rifpc_top #(.IRQ_LINES(4)) i_dut (.sys_clk(sys_clk), .reset(reset),
    .reset_pin_n(reset_pin_n), .hold_req_n(hold_req_n), .ext_irq_lines(ext_irq_lines),
    .flag_pin_zero_in(f0_in), .flag_pin_one_in(f1_in), .flag_pin_zero_drv(f0_drv),
    .flag_pin_one_drv(f1_drv), .periph_pins_oe_n(periph_pins_oe_n), .bus_ctl(bus_ctl),
    .irq_ack_strobe(irq_ack_strobe), .hold_ack(hold_ack),
    .store_addr_drive(store_addr_drive), .clock_phase_a(clock_phase_a),
    .clock_phase_b(clock_phase_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  rifpc_far_side i_far (.sys_clk(sys_clk), .rst_req(rst_req), .irq_go(irq_go),
    .irq_level(irq_level), .hold_req(hold_req), .flag_level(flag_level),
    .flag_pin_zero_drv(f0_drv), .flag_pin_one_drv(f1_drv), .reset_pin_n(reset_pin_n),
    .ext_irq_lines(ext_irq_lines), .hold_req_n(hold_req_n),
    .flag_pin_zero_in(f0_in), .flag_pin_one_in(f1_in));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one single word transfer; read data lands in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // wait a bounded time for a flag pin to reach {out, oe_n}
  task wpin(input logic s, input logic [1:0] e);
    for (k = 0; k < 12 && (s ? f1_drv : f0_drv) !== e; k++) @(posedge sys_clk);
  endtask
  task pulse(input logic [3:0] m);
    irq_go <= m;
    @(posedge sys_clk);
    irq_go <= 4'h0;
    repeat (6) @(posedge sys_clk);
  endtask
  task summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
    chk({f0_drv.oe_n, f1_drv.oe_n, periph_pins_oe_n}, 3'h7);
    chk(bus_ctl, 4'hF);
    chk(irq_ack_strobe, 1);
    hold_req <= 1'b1;
    for (k = 0; k < 12 && hold_ack !== 1'b1; k++) @(posedge sys_clk);
    chk(hold_ack, 1);
    hold_req <= 1'b0;
    bus(0, `RIFPC_OFS_BUSCTL, 0);
    chk(q, 7);
    rst_req <= 1'b0;
    for (k = 0; k < 60 && periph_pins_oe_n !== 1'b0; k++) @(posedge sys_clk);
    chk({periph_pins_oe_n, bus_ctl.bus_release}, 0);
    $display("reset test done");
  endtask
  task t_phase;
    for (n = 0; n < 6; n++) begin
      p = clock_phase_a;
      @(negedge sys_clk);
      chk({clock_phase_a, clock_phase_b}, {!p, p});
    end
    $display("phase test done");
  endtask
  // both flags as outputs (bits 1,5), values in bits 2,6; partner pulls opposite
  task t_flag_out;
    for (n = 0; n < 2; n++) begin
      d = n ? 32'h66 : 32'h22;
      flag_level <= !n[0];
      bus(1, `RIFPC_OFS_FLAGCTL, d);
      wpin(0, {n[0], 1'b0});
      chk(f0_drv, {n[0], 1'b0});
      wpin(1, {n[0], 1'b0});
      chk(f1_drv, {n[0], 1'b0});
      bus(0, `RIFPC_OFS_FLAGCTL, 0);
      chk(q & 32'h66, d);
    end
    $display("flag output test done");
  endtask
  // inputs land in bits 3,7 after the sync chain and a phase-a fall
  task t_flag_in;
    bus(1, `RIFPC_OFS_FLAGCTL, 32'h88);
    for (n = 0; n < 2; n++) begin
      flag_level <= n[0];
      repeat (8) @(posedge sys_clk);
      chk({f0_drv.oe_n, f1_drv.oe_n}, 2'h3);
      bus(0, `RIFPC_OFS_FLAGCTL, 0);
      chk(q & 32'h88, n ? 32'h88 : 0);
    end
    $display("flag input test done");
  endtask
  task t_irq;
    pulse(4'h4);
    bus(0, `RIFPC_OFS_IRQ, 0);
    chk(q, 4);
    bus(1, `RIFPC_OFS_CORE, 32'h10);
    bus(0, `RIFPC_OFS_IRQ, 0);
    chk(q, 0);
    irq_level <= 4'h2;
    pulse(4'h0);
    bus(1, `RIFPC_OFS_CORE, 32'h10);
    // a held level is caught again at a later fall once the boundary cleared it
    pulse(4'h0);
    bus(0, `RIFPC_OFS_IRQ, 0);
    chk(q, 2);
    irq_level <= 4'h0;
    pulse(4'h1);
    bus(1, `RIFPC_OFS_CORE, 32'h10);
    pulse(4'h1);
    bus(0, `RIFPC_OFS_IRQ, 0);
    chk(q, 1);
    $display("interrupt test done");
  endtask
  task t_ack;
    bus(1, `RIFPC_OFS_CORE, 32'h1);
    for (k = 0; k < 12 && irq_ack_strobe !== 1'b0; k++) @(posedge sys_clk);
    chk(irq_ack_strobe, 0);
    for (k = 0; k < 12 && irq_ack_strobe !== 1'b1; k++) @(posedge sys_clk);
    chk(irq_ack_strobe, 1);
    $display("acknowledge test done");
  endtask
  // load, then a store stalled by hold, then signal interlock
  task t_lock;
    bus(1, `RIFPC_OFS_CORE, 32'h4);
    wpin(0, 2'h0);
    chk(f0_drv, 2'h0);
    hold_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    bus(1, `RIFPC_OFS_CORE, 32'h2);
    wpin(0, 2'h2);
    chk(f0_drv, 2'h2);
    p = 1'b0;
    repeat (6) @(posedge sys_clk) p = p | store_addr_drive;
    chk(p, 0);
    hold_req <= 1'b0;
    for (k = 0; k < 12 && store_addr_drive !== 1'b1; k++) @(posedge sys_clk);
    chk(store_addr_drive, 1);
    bus(1, `RIFPC_OFS_CORE, 32'h8);
    wpin(0, 2'h0);
    chk(f0_drv, 2'h0);
    wpin(0, 2'h2);
    chk(f0_drv, 2'h2);
    $display("interlock test done");
  endtask
  task t_map;
    bus(0, 8'h20, 0);
    chk(q, 0);
    bus(1, `RIFPC_OFS_CORE, 32'h20);
    bus(0, `RIFPC_OFS_CORE, 0);
    chk(q & 32'h20, 32'h20);
    $display("map test done");
  endtask

  // 50 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    fails++;
    summarize;
  end
  // main sequence
  initial begin
    {reset, rst_req, hsize} = 5'h1A;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {hold_req, flag_level, irq_go, irq_level} = '0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset;
    t_phase;
    t_flag_out;
    t_flag_in;
    t_irq;
    t_ack;
    t_lock;
    t_map;
    summarize;
  end
endmodule // test_reset_irq_flag_pin_control
